// ### src/sac_pkg.sv
// Purpose: Shared constants and types for the serial converter control block
// Assumes: 125 MHz system clock, all pins sampled through two flip-flops
// Notes: Mode word decode codes are local choices, kept here so they can be retuned
//
// Overview of operation
// - Capture serial input on shift-clock rise, select low
// - Shift next result bit on shift-clock fall
// - Select held low: first bit at busy rise
// - Select toggled: first bit on select fall
// - Output driven while selected, released otherwise
// - Busy low during convert, calibrate, zero, power-down
// - Select fall aborts conversion, starts new sequence
// - Thirteen shift clocks per sequence after reset
// - Clocks per sequence equal programmed word length
// - Result shifts out in programmed length, format
// - Output-ready low while shifting, high when done
// - Program enable low loads mode when idle; high reads only
// - Read-only: shift stored data, no change, no start
// - Power down while input high, up when low
// - Ready within 700 us, busy until then
// - Channel from captured address bits
// - Result is 12-bit plus sign two's complement
// - Single-ended mode uses common input as negative
package sac_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int PWRUP_US = 700;
    // Longest time, exact in whole cycles
    localparam int PWRUP_CYCLES = PWRUP_US * CLK_MHZ;
    localparam int CNT_W = 17;
    // Conversion-clock periods per cycle kind
    localparam logic [16:0] CVT_TICKS = 17'h00036;
    localparam logic [16:0] CAL_TICKS = 17'h01350;
    localparam logic [16:0] ZERO_TICKS = 17'h0004c;

    ////////////////////////////////////////////////////////////////////////////
    // Mode word layout
    localparam int MODE_BITS = 8;
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 5;
    localparam int SE_BIT = 4;
    localparam int CH_MSB = 2;
    localparam logic [4:0] MODE_BITS_W = 5'h08;
    localparam logic [4:0] LEN_13 = 5'h0d;
    localparam logic [4:0] LEN_9 = 5'h09;
    localparam logic [4:0] LEN_17 = 5'h11;
    localparam int OUT_W = 17;
    localparam int RES_W = 13;

    typedef enum logic [2:0] {
        OP_CONV12 = 3'h0,
        OP_CONV8 = 3'h1,
        OP_CONV17 = 3'h2,
        OP_CAL = 3'h3,
        OP_ZERO = 3'h4,
        OP_NOP = 3'h7
    } sac_op_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_CVT = 6'h02,
        ST_CAL = 6'h04,
        ST_ZERO = 6'h08,
        ST_PDN = 6'h10,
        ST_PUP = 6'h20
    } sac_state_t;

    typedef struct packed {
        logic [2:0] channel;
        logic single_ended;
        logic res8;
        logic [4:0] word_len;
    } sac_cfg_t;

    typedef struct packed {
        sac_op_t op;
        sac_cfg_t cfg;
    } sac_cmd_t;

    typedef struct packed {
        logic cvt_clk;
        logic pwr_dn;
        logic prog_n;
        logic din;
        logic cs_n;
        logic sclk;
    } sac_pins_t;

    localparam sac_cfg_t CFG_RESET = '{channel: 3'h0, single_ended: 1'b0, res8: 1'b0,
                                       word_len: LEN_13};
    localparam sac_pins_t PINS_IDLE = '{cvt_clk: 1'b0, pwr_dn: 1'b0, prog_n: 1'b1, din: 1'b0,
                                        cs_n: 1'b1, sclk: 1'b0};

endpackage : sac_pkg

// ### src/sac_sync.sv
// Purpose: Two-flop synchroniser for all pins entering the clock domain
// Assumes: Pins are slow against the 8 ns clock
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
module sac_sync (
    input wire logic clk,
    input wire logic srst,
    input wire sac_pkg::sac_pins_t pins_in,
    output sac_pkg::sac_pins_t pins_out
);

    typedef struct packed {
        sac_pkg::sac_pins_t stage1;
        sac_pkg::sac_pins_t stage2;
    } sac_sync_t;

    sac_sync_t sync_reg;
    sac_sync_t sync_next;

    always_comb begin
        sync_next.stage1 = pins_in;
        sync_next.stage2 = sync_reg.stage1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_reg <= '{stage1: sac_pkg::PINS_IDLE, stage2: sac_pkg::PINS_IDLE};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign pins_out = sync_reg.stage2;

endmodule : sac_sync

// ### src/sac_mode_decode.sv
// Purpose: Mode word to command and configuration
// Assumes: Word is the first eight bits shifted in, first bit in the top position
// Notes: Unknown codes leave the configuration as it was
`timescale 1ns/1ps
module sac_mode_decode (
    input wire logic [7:0] mode_word,
    input wire sac_pkg::sac_cfg_t cur_cfg,
    output sac_pkg::sac_cmd_t cmd
);

    logic [2:0] op_code;

    // Single table for all encodings, swap here to retarget
    always_comb begin
        op_code = mode_word[sac_pkg::OP_MSB:sac_pkg::OP_LSB];
        cmd.cfg = cur_cfg;
        cmd.op = sac_pkg::OP_NOP;
        case (op_code)
            sac_pkg::OP_CONV12, sac_pkg::OP_CONV8, sac_pkg::OP_CONV17: begin
                cmd.op = sac_pkg::sac_op_t'(op_code);
                cmd.cfg.channel = mode_word[sac_pkg::CH_MSB:0];
                cmd.cfg.single_ended = mode_word[sac_pkg::SE_BIT];
                cmd.cfg.res8 = (op_code == sac_pkg::OP_CONV8);
                cmd.cfg.word_len = (op_code == sac_pkg::OP_CONV8) ? sac_pkg::LEN_9 :
                                   (op_code == sac_pkg::OP_CONV17) ? sac_pkg::LEN_17 :
                                   sac_pkg::LEN_13;
            end
            sac_pkg::OP_CAL: begin
                cmd.op = sac_pkg::OP_CAL;
            end
            sac_pkg::OP_ZERO: begin
                cmd.op = sac_pkg::OP_ZERO;
            end
            default: begin
                cmd.op = sac_pkg::OP_NOP;
            end
        endcase
    end

endmodule : sac_mode_decode

// ### src/sac_top.sv
// Purpose: Serial interface and cycle sequencer of a sampling converter
// Assumes: adc_sample is on the clk domain and stable when a conversion ends
// Notes: Shift clock and conversion clock are sampled, so both must stay well below 62 MHz
`timescale 1ns/1ps
module sac_top #(
    parameter int POWERUP_CYCLES = sac_pkg::PWRUP_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_input,
    input wire logic program_enable_n,
    input wire logic power_down_input,
    input wire logic conversion_clock,
    input wire logic [12:0] adc_sample,
    output logic serial_out,
    output logic serial_out_oe,
    output logic busy_done,
    output logic output_ready,
    output logic sample_req,
    output logic [2:0] mux_channel,
    output logic mux_single_ended,
    output logic neg_ref_is_com
);

    typedef struct packed {
        sac_pkg::sac_state_t st;
        logic [7:0] in_sr;
        logic [16:0] out_sr;
        logic [12:0] result;
        logic [4:0] bit_cnt;
        sac_pkg::sac_cfg_t cfg;
        logic [16:0] cnt;
        logic sclk_d;
        logic cs_d;
        logic cvt_d;
        logic so;
        logic so_oe;
        logic busy;
        logic oready;
        logic sample_req;
    } sac_top_t;

    localparam logic [16:0] PWRUP_LAST = 17'(POWERUP_CYCLES - 1);

    sac_top_t top_reg;
    sac_top_t top_next;
    sac_pkg::sac_pins_t pins_raw;
    sac_pkg::sac_pins_t p;
    sac_pkg::sac_cmd_t cmd;

    ////////////////////////////////////////////////////////////////////////////
    // Pin entry and mode decode
    assign pins_raw = '{cvt_clk: conversion_clock, pwr_dn: power_down_input,
                        prog_n: program_enable_n, din: serial_input, cs_n: cs_n, sclk: sclk};

    sac_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pins_in(pins_raw),
        .pins_out(p)
    );

    sac_mode_decode u_decode (
        .mode_word(top_reg.in_sr),
        .cur_cfg(top_reg.cfg),
        .cmd(cmd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output word layout, first bit in the top position
    function automatic logic [16:0] fmt_word(input logic [12:0] res,
                                             input sac_pkg::sac_cfg_t c);
        logic [16:0] w;
        w = {res, 4'h0};
        if (c.word_len == sac_pkg::LEN_17) begin
            w = {{4{res[12]}}, res};
        end else if (c.res8) begin
            w = {res[12:4], 8'h00};
        end
        return w;
    endfunction : fmt_word

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        logic sclk_rise;
        logic sclk_fall;
        logic cs_fall;
        logic cvt_rise;
        logic done;
        logic running;
        logic present;
        logic seq_end;
        logic [16:0] word;
        sclk_rise = p.sclk & ~top_reg.sclk_d;
        sclk_fall = ~p.sclk & top_reg.sclk_d;
        cs_fall = ~p.cs_n & top_reg.cs_d;
        cvt_rise = p.cvt_clk & ~top_reg.cvt_d;
        done = 1'b0;
        present = 1'b0;
        seq_end = 1'b0;
        running = (top_reg.st == sac_pkg::ST_CVT) || (top_reg.st == sac_pkg::ST_CAL) ||
                  (top_reg.st == sac_pkg::ST_ZERO);
        word = 17'h00000;
        top_next = top_reg;
        top_next.sample_req = 1'b0;
        top_next.sclk_d = p.sclk;
        top_next.cs_d = p.cs_n;
        top_next.cvt_d = p.cvt_clk;
        top_next.so_oe = ~p.cs_n;

        if (p.pwr_dn) begin
            top_next.st = sac_pkg::ST_PDN;
            top_next.busy = 1'b0;
        end else begin
            case (top_reg.st)
                sac_pkg::ST_PDN: begin
                    top_next.st = sac_pkg::ST_PUP;
                    top_next.cnt = PWRUP_LAST;
                end
                sac_pkg::ST_PUP: begin
                    if (top_reg.cnt == 17'h00000) begin
                        top_next.st = sac_pkg::ST_IDLE;
                        top_next.busy = 1'b1;
                    end else begin
                        top_next.cnt = top_reg.cnt - 17'h00001;
                    end
                end
                sac_pkg::ST_CVT, sac_pkg::ST_CAL, sac_pkg::ST_ZERO: begin
                    if (cvt_rise) begin
                        if (top_reg.cnt == 17'h00000) begin
                            top_next.st = sac_pkg::ST_IDLE;
                            top_next.busy = 1'b1;
                            done = 1'b1;
                            if (top_reg.st == sac_pkg::ST_CVT) begin
                                top_next.result = adc_sample;
                            end
                        end else begin
                            top_next.cnt = top_reg.cnt - 17'h00001;
                        end
                    end
                end
                default: begin
                    top_next.st = top_reg.st;
                end
            endcase
        end

        if (cs_fall) begin
            // Stale word goes out; host discards it after an abort
            if (running && !p.pwr_dn) begin
                top_next.st = sac_pkg::ST_IDLE;
                top_next.busy = 1'b1;
            end
            present = 1'b1;
        end else if (!p.cs_n) begin
            if (done) begin
                present = 1'b1;
            end
            // The fall after the last rise closes the frame and shifts nothing
            if (sclk_fall && top_reg.bit_cnt != 5'h00) begin
                top_next.so = top_reg.out_sr[16];
                top_next.out_sr = {top_reg.out_sr[15:0], 1'b0};
                top_next.oready = 1'b0;
            end
            if (sclk_rise) begin
                if (top_reg.bit_cnt < sac_pkg::MODE_BITS_W) begin
                    top_next.in_sr = {top_reg.in_sr[6:0], p.din};
                end
                top_next.bit_cnt = top_reg.bit_cnt + 5'h01;
                if (top_reg.bit_cnt + 5'h01 == top_reg.cfg.word_len) begin
                    top_next.bit_cnt = 5'h00;
                    top_next.oready = 1'b1;
                    seq_end = 1'b1;
                    // Starting only from idle relies on the host never reading mid-cycle
                    if (!p.prog_n && top_reg.st == sac_pkg::ST_IDLE) begin
                        top_next.cfg = cmd.cfg;
                        case (cmd.op)
                            sac_pkg::OP_CONV12, sac_pkg::OP_CONV8, sac_pkg::OP_CONV17: begin
                                top_next.st = sac_pkg::ST_CVT;
                                top_next.cnt = sac_pkg::CVT_TICKS - 17'h00001;
                                top_next.busy = 1'b0;
                                top_next.sample_req = 1'b1;
                            end
                            sac_pkg::OP_CAL: begin
                                top_next.st = sac_pkg::ST_CAL;
                                top_next.cnt = sac_pkg::CAL_TICKS - 17'h00001;
                                top_next.busy = 1'b0;
                            end
                            sac_pkg::OP_ZERO: begin
                                top_next.st = sac_pkg::ST_ZERO;
                                top_next.cnt = sac_pkg::ZERO_TICKS - 17'h00001;
                                top_next.busy = 1'b0;
                            end
                            default: begin
                                present = 1'b1;
                            end
                        endcase
                    end else begin
                        present = 1'b1;
                    end
                end
            end
        end

        if (present) begin
            word = fmt_word(top_next.result, top_next.cfg);
            top_next.so = word[16];
            top_next.out_sr = {word[15:0], 1'b0};
            top_next.bit_cnt = 5'h00;
            // Set wins: a word re-presented at frame end has not started shifting
            top_next.oready = seq_end;
        end
        if (p.cs_n) begin
            top_next.so = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            top_reg <= '{st: sac_pkg::ST_IDLE, in_sr: 8'h00, out_sr: 17'h00000,
                         result: 13'h0000, bit_cnt: 5'h00, cfg: sac_pkg::CFG_RESET,
                         cnt: 17'h00000, sclk_d: 1'b0, cs_d: 1'b1, cvt_d: 1'b0,
                         so: 1'b0, so_oe: 1'b0, busy: 1'b1, oready: 1'b1,
                         sample_req: 1'b0};
        end else begin
            top_reg <= top_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign serial_out = top_reg.so;
    assign serial_out_oe = top_reg.so_oe;
    assign busy_done = top_reg.busy;
    assign output_ready = top_reg.oready;
    assign sample_req = top_reg.sample_req;
    assign mux_channel = top_reg.cfg.channel;
    assign mux_single_ended = top_reg.cfg.single_ended;
    assign neg_ref_is_com = top_reg.cfg.single_ended;

endmodule : sac_top

// ### testbench/sac_sva.sv
// Purpose: Port assertions for the converter control block
// Assumes: Bound to sac_top, one clock domain
// Notes: Pins reach the outputs about three clocks late
`timescale 1ns/1ps
module sac_sva #(
    parameter int POWERUP_CYCLES = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic power_down_input,
    input wire logic serial_out_oe,
    input wire logic busy_done,
    input wire logic output_ready,
    input wire logic sample_req
);
    logic pwr_dn_reg;
    logic pu_reg;
    int pu_cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Power-up wait is counted, being too long for a delay range
    always_ff @(posedge clk) begin
        pwr_dn_reg <= power_down_input;
        pu_reg <= !srst && !busy_done && (pu_reg || (pwr_dn_reg && !power_down_input));
        pu_cnt_reg <= pu_reg ? pu_cnt_reg + 1 : 0;
    end
    ////////////////////////////////////////////////////////////
    property p_sel; $fell(cs_n) |-> ##[2:6] serial_out_oe && !output_ready; endproperty
    a_sel: assert property (p_sel) else $error("no word on select");
    property p_desel; cs_n [*4] |-> !serial_out_oe; endproperty
    a_desel: assert property (p_desel) else $error("output driven");
    property p_eoc; $rose(busy_done) && !cs_n |-> ##[0:2] !output_ready; endproperty
    a_eoc: assert property (p_eoc) else $error("no word at end");
    property p_abort;
        $fell(cs_n) && !busy_done && !power_down_input |-> ##[1:6] busy_done; endproperty
    a_abort: assert property (p_abort) else $error("cycle not ended");
    property p_pdn; power_down_input [*4] |-> !busy_done; endproperty
    a_pdn: assert property (p_pdn) else $error("busy high in power-down");
    property p_pup; $fell(power_down_input) |-> !busy_done [*8]; endproperty
    a_pup: assert property (p_pup) else $error("ready too soon");
    property p_pup_max; pu_cnt_reg <= POWERUP_CYCLES + 6; endproperty
    a_pup_max: assert property (p_pup_max) else $error("ready too late");
    property p_req; sample_req |=> !sample_req && !busy_done; endproperty
    a_req: assert property (p_req) else $error("start not busy");
endmodule : sac_sva

// ### testbench/sac_host.sv
// Purpose: Host serial master for the converter control block
// Assumes: Link clock of 20 system clocks, 10 high then 10 low
// Notes: Link clock stands still between frames
`timescale 1ns/1ps
module sac_host (
    input wire logic clk,
    input wire logic serial_out,
    input wire logic output_ready,
    output logic sclk,
    output logic cs_n,
    output logic serial_input,
    output logic program_enable_n
);
    logic [16:0] word;
    logic rdy_seen;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_input = 1'b0;
        program_enable_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // One frame of n link clocks; keep leaves select low afterwards
    task automatic xfer(input logic [7:0] md, input int n, input logic ro, input logic keep);
        word = '0;
        rdy_seen = 1'b0;
        program_enable_n <= ro;
        serial_input <= md[7];
        cs_n <= 1'b0;
        tick(10);
        for (int i = 0; i < n; i++) begin
            word = {word[15:0], serial_out};
            rdy_seen = rdy_seen | output_ready;
            sclk <= 1'b1;
            tick(10);
            sclk <= 1'b0;
            // Past the mode bits the line keeps changing
            serial_input <= (i < 7) ? md[6 - i] : ~serial_input;
            tick(10);
        end
        cs_n <= !keep;
        tick(20);
    endtask : xfer
endmodule : sac_host

// ### testbench/test_sac_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Host model owns the serial pins; conversion clock is clk/4
// Notes: Power-up wait shortened to 20 clocks
`timescale 1ns/1ps
module test_sac_top;
    localparam int PU = 20;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic power_down_input = 1'b0;
    logic [1:0] cdiv = 2'h0;
    logic [12:0] adc_sample = 13'h0000;
    logic sclk, cs_n, serial_input, program_enable_n, serial_out, serial_out_oe;
    logic busy_done, output_ready, sample_req, mux_single_ended, neg_ref_is_com;
    logic [2:0] mux_channel;
    int miscompares = 0;
    int n_compared = 0;
    always #4 clk = ~clk;
    always @(posedge clk) cdiv <= cdiv + 2'h1;
    sac_top #(.POWERUP_CYCLES(PU)) dut (.clk, .srst, .sclk, .cs_n, .serial_input,
        .program_enable_n, .power_down_input, .conversion_clock(cdiv[1]), .adc_sample,
        .serial_out, .serial_out_oe, .busy_done, .output_ready, .sample_req,
        .mux_channel, .mux_single_ended, .neg_ref_is_com);
    sac_host host (.clk, .serial_out, .output_ready, .sclk, .cs_n, .serial_input,
        .program_enable_n);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_busy(input int lim);
        for (int k = 0; k < lim && busy_done !== 1'b1; k++) begin
            @(posedge clk);
        end
        chk(busy_done, 1'b1);
    endtask : wait_busy
    task automatic summarize;
        if (miscompares == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    // Program a single-ended conversion, then read it back only
    task automatic t_program_enable_n;
        chk({busy_done, output_ready, serial_out_oe, mux_channel}, 6'h30);
        adc_sample <= 13'h1a5c;
        host.xfer(8'h15, 13, 1'b0, 1'b0);
        chk(host.word, 17'h0);
        chk(busy_done, 1'b0);
        wait_busy(400);
        chk({mux_channel, mux_single_ended, neg_ref_is_com}, 5'h17);
        host.xfer(8'h00, 13, 1'b1, 1'b0);
        chk(host.word, 17'h1a5c);
        chk({busy_done, output_ready, host.rdy_seen, mux_channel}, 6'h35);
    endtask : t_program_enable_n
    // Word length follows each mode; the sign fills the long word
    task automatic t_len;
        logic [7:0] md [3] = '{8'h40, 8'h20, 8'h03};
        int ln [3] = '{17, 9, 13};
        logic [12:0] smp [3] = '{13'h1f00, 13'h0abc, 13'h0fff};
        logic [16:0] ex [3] = '{17'h1ff00, 17'h000ab, 17'h00fff};
        int cur = 13;
        for (int i = 0; i < 3; i++) begin
            adc_sample <= smp[i];
            host.xfer(md[i], cur, 1'b0, 1'b0);
            wait_busy(400);
            host.xfer(8'hff, ln[i], 1'b1, 1'b0);
            chk(host.word, ex[i]);
            chk({output_ready, host.rdy_seen}, 2'h2);
            cur = ln[i];
        end
    endtask : t_len
    // Calibration and zeroing hold busy low and keep the channel
    task automatic t_cal;
        logic [7:0] md [2] = '{8'h60, 8'h80};
        int lim [2] = '{21000, 600};
        for (int i = 0; i < 2; i++) begin
            host.xfer(md[i], 13, 1'b0, 1'b0);
            chk(busy_done, 1'b0);
            wait_busy(lim[i]);
            chk(mux_channel, 3'h3);
        end
    endtask : t_cal
    // Select held low: the new word starts when busy rises
    task automatic t_cont;
        adc_sample <= 13'h0123;
        host.xfer(8'h00, 13, 1'b0, 1'b1);
        wait_busy(400);
        host.xfer(8'he0, 13, 1'b0, 1'b0);
        chk(host.word, 17'h0123);
    endtask : t_cont
    // Select raised and lowered again in mid-conversion
    task automatic t_abort;
        host.xfer(8'h00, 13, 1'b0, 1'b1);
        chk(busy_done, 1'b0);
        host.xfer(8'h00, 0, 1'b0, 1'b0);
        host.xfer(8'he0, 13, 1'b0, 1'b0); // word ignored
        chk(busy_done, 1'b1);
    endtask : t_abort
    task automatic t_pdn;
        power_down_input <= 1'b1;
        host.tick(8);
        chk(busy_done, 1'b0);
        power_down_input <= 1'b0;
        host.tick(PU - 4);
        chk(busy_done, 1'b0);
        host.tick(12);
        chk(busy_done, 1'b1);
    endtask : t_pdn
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        t_program_enable_n();
        t_len();
        t_cal();
        t_cont();
        t_abort();
        t_pdn();
        summarize();
    end
    // About twice the expected run
    initial begin
        #480000;
        miscompares++;
        summarize();
    end
endmodule : test_sac_top
bind sac_top sac_sva #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_sva (.clk, .srst, .cs_n,
    .power_down_input, .serial_out_oe, .busy_done, .output_ready, .sample_req);
